/* inc/cogc_pkg.sv */
package cogc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [31:0] COGC_IDX_OUT_A = 32'h0000_5064;
  localparam logic [31:0] COGC_IDX_OUT_B = 32'h0000_5065;
  localparam logic [31:0] COGC_IDX_WAIT = 32'h0000_507D;
  localparam logic [31:0] COGC_IDX_GATE = 32'h0000_5080;
  localparam logic [31:0] COGC_IDX_CORE = 32'h0000_5081;
  localparam logic [31:0] COGC_ADDR_OUT_A = COGC_IDX_OUT_A << 2;
  localparam logic [31:0] COGC_ADDR_OUT_B = COGC_IDX_OUT_B << 2;
  localparam logic [31:0] COGC_ADDR_WAIT = COGC_IDX_WAIT << 2;
  localparam logic [31:0] COGC_ADDR_GATE = COGC_IDX_GATE << 2;
  localparam logic [31:0] COGC_ADDR_CORE = COGC_IDX_CORE << 2;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int COGC_DIV_LSB = 4;
  localparam int COGC_DIV_MSB = 6;
  localparam int COGC_SRC_LSB = 2;
  localparam int COGC_SRC_MSB = 3;
  localparam int COGC_EN_BIT = 0;
  localparam int COGC_FWT_LSB = 6;
  localparam int COGC_FWT_MSB = 7;
  localparam int COGC_SWT_LSB = 0;
  localparam int COGC_SWT_MSB = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] COGC_RST_OUT = 8'h00;
  localparam logic [7:0] COGC_RST_WAIT = 8'h00;
  localparam logic [1:0] COGC_RST_GATE = 2'h3;
  localparam logic [1:0] COGC_RST_GEAR = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // encodings
  localparam logic [1:0] COGC_SRC_FAST = 2'h0;
  localparam logic [1:0] COGC_SRC_SLOW = 2'h1;
  localparam logic [1:0] COGC_GATE_ON = 2'h3;
  localparam logic [1:0] COGC_GATE_OFF = 2'h0;
  localparam logic [1:0] COGC_SWT_LONG = 2'h0;
  localparam logic [1:0] COGC_SWT_SHORT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // timing counts in oscillator cycles, wait counter width, system clock period in ns
  localparam logic [14:0] COGC_FWT_BASE = 15'h0040;
  localparam int COGC_SWT_LONG_CYC = 16384;
  localparam int COGC_SWT_SHORT_CYC = 4096;
  localparam int COGC_WAIT_W = 15;
  localparam int COGC_CLK_PERIOD_NS = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave states
  typedef enum logic [0:0] {
    COGC_ST_IDLE = 1'b0,
    COGC_ST_DATA = 1'b1
  } cogc_state_t;

endpackage

/* rtl/cogc_clkout.sv */
`timescale 1ns/1ps
module cogc_clkout (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // synchronised oscillators
  input wire logic fast_lvl_i,
  input wire logic fast_rise_i,
  input wire logic slow_lvl_i,
  input wire logic slow_rise_i,
  // settings
  input wire logic [1:0] src_i,
  input wire logic [2:0] div_i,
  input wire logic en_i,
  // divided clock
  output logic clk_o
);
  import cogc_pkg::*;

  logic [6:0] cnt_q;
  logic sel_lvl;
  logic sel_rise;
  logic sel_valid;
  logic div_lvl;
  logic clk_q;

  // source selection, reserved codes give no clock
  always_comb begin
    sel_lvl = 1'b0;
    sel_rise = 1'b0;
    sel_valid = 1'b0;
    case (src_i)
      COGC_SRC_FAST: begin
        sel_lvl = fast_lvl_i;
        sel_rise = fast_rise_i;
        sel_valid = 1'b1;
      end
      COGC_SRC_SLOW: begin
        sel_lvl = slow_lvl_i;
        sel_rise = slow_rise_i;
        sel_valid = 1'b1;
      end
      default: begin
        sel_valid = 1'b0;
      end
    endcase
  end

  // synchronous count of source rising edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 7'h00;
    end else if (sel_rise) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // bit n-1 of the count is the source divided by 2^n
  assign div_lvl = (div_i == 3'h0) ? sel_lvl : cnt_q[3'(div_i - 3'h1)];

  // gated output register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= en_i & sel_valid & div_lvl;
    end
  end

  assign clk_o = clk_q;

  // divide by one passes the selected level through
  div_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && div_i == 3'h0 && src_i == COGC_SRC_SLOW) |=> (clk_o == $past(slow_lvl_i)))
    else $error("divide by one does not follow slow source");

  // reserved source gives a quiet output
  src_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_i[1] == 1'b1) |=> !clk_o)
    else $error("reserved source produced a clock");

endmodule

/* rtl/cogc_top.sv */
// Operation
// - first output divides its source by 1 to 128 per bits 6..4, reset 0.
// - source bits 3..2 pick fast oscillator at 0, slow at 1; others reserved.
// - second output has the same fields in its own register; each drives only when its enable bit is 1.
// - fast oscillator wait of 64, 32, 16 or 8 cycles per bits 7..6.
// - slow oscillator wait of 16384 cycles at code 0, 4096 at code 2.
// - core clock divided by 1,2,4,8 by gear; peripheral gate on at 3, off at 0.
`timescale 1ns/1ps
module cogc_top #(
  parameter int SLOW_WAIT_LONG = cogc_pkg::COGC_SWT_LONG_CYC,
  parameter int SLOW_WAIT_SHORT = cogc_pkg::COGC_SWT_SHORT_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // oscillator pins and enables
  input wire logic FAST_OSC_I,
  input wire logic SLOW_OSC_I,
  input wire logic FAST_OSC_EN_I,
  input wire logic SLOW_OSC_EN_I,
  // clock outputs, oscillator ready flags and clock enables
  output logic CLOCK_OUTPUT_FIRST_O,
  output logic CLOCK_OUTPUT_SECOND_O,
  output logic FAST_OSC_READY_O,
  output logic SLOW_OSC_READY_O,
  output logic PERIPH_CLK_EN_O,
  output logic CORE_CLK_EN_O
);
  import cogc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // parameter checks
  if (SLOW_WAIT_LONG < 1 || SLOW_WAIT_LONG >= (1 << COGC_WAIT_W)) begin : g_chk_long
    $error("SLOW_WAIT_LONG out of range");
  end
  if (SLOW_WAIT_SHORT < 1 || SLOW_WAIT_SHORT >= (1 << COGC_WAIT_W)) begin : g_chk_short
    $error("SLOW_WAIT_SHORT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  cogc_state_t state_q;
  logic [31:0] addr_q;
  logic write_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic accept;
  logic wr_en;
  logic [7:0] rd_mux;
  logic [6:0] out_a_q;
  logic [6:0] out_b_q;
  logic [1:0] fast_wt_q;
  logic [1:0] slow_wt_q;
  logic [1:0] gate_q;
  logic [1:0] gear_q;
  logic fast_s1_q;
  logic fast_s2_q;
  logic fast_s3_q;
  logic slow_s1_q;
  logic slow_s2_q;
  logic slow_s3_q;
  logic fast_rise;
  logic slow_rise;
  logic [COGC_WAIT_W-1:0] fast_cnt_q;
  logic [COGC_WAIT_W-1:0] slow_cnt_q;
  logic [COGC_WAIT_W-1:0] fast_target;
  logic [COGC_WAIT_W-1:0] slow_target;
  logic fast_rdy_q;
  logic slow_rdy_q;
  logic [2:0] gear_cnt_q;
  logic [2:0] gear_mask;
  logic core_en_q;
  logic pclk_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, every transfer answers okay
  assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign wr_en = (state_q == COGC_ST_DATA) && write_q;

  // address phase capture and data phase sequencing
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= COGC_ST_IDLE;
      addr_q <= 32'h0000_0000;
      write_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      case (state_q)
        COGC_ST_IDLE: begin
          if (accept) begin
            state_q <= COGC_ST_DATA;
            addr_q <= HADDR_I;
            write_q <= HWRITE_I;
            ready_q <= 1'b0;
          end
        end
        COGC_ST_DATA: begin
          state_q <= COGC_ST_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= COGC_ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // read multiplexer, reserved bits and unmapped addresses read zero
  always_comb begin
    case (addr_q)
      COGC_ADDR_OUT_A: rd_mux = {1'b0, out_a_q};
      COGC_ADDR_OUT_B: rd_mux = {1'b0, out_b_q};
      COGC_ADDR_WAIT: rd_mux = {fast_wt_q, 4'h0, slow_wt_q};
      COGC_ADDR_GATE: rd_mux = {6'h00, gate_q};
      COGC_ADDR_CORE: rd_mux = {6'h00, gear_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == COGC_ST_DATA && !write_q) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign HRDATA_O = rdata_q;
  assign HREADYOUT_O = ready_q;
  assign HRESP_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  // clock output settings: divider, source, enable
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      out_a_q <= COGC_RST_OUT[6:0];
      out_b_q <= COGC_RST_OUT[6:0];
    end else if (wr_en) begin
      if (addr_q == COGC_ADDR_OUT_A) begin
        out_a_q <= {HWDATA_I[COGC_DIV_MSB:COGC_SRC_LSB], 1'b0, HWDATA_I[COGC_EN_BIT]};
      end
      if (addr_q == COGC_ADDR_OUT_B) begin
        out_b_q <= {HWDATA_I[COGC_DIV_MSB:COGC_SRC_LSB], 1'b0, HWDATA_I[COGC_EN_BIT]};
      end
    end
  end

  // oscillator settle wait selections
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fast_wt_q <= COGC_RST_WAIT[COGC_FWT_MSB:COGC_FWT_LSB];
      slow_wt_q <= COGC_RST_WAIT[COGC_SWT_MSB:COGC_SWT_LSB];
    end else if (wr_en && addr_q == COGC_ADDR_WAIT) begin
      fast_wt_q <= HWDATA_I[COGC_FWT_MSB:COGC_FWT_LSB];
      slow_wt_q <= HWDATA_I[COGC_SWT_MSB:COGC_SWT_LSB];
    end
  end

  // peripheral gate keeps its value on forbidden codes; core gear
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gate_q <= COGC_RST_GATE;
      gear_q <= COGC_RST_GEAR;
    end else if (wr_en) begin
      if (addr_q == COGC_ADDR_GATE && (HWDATA_I[1:0] == COGC_GATE_ON ||
          HWDATA_I[1:0] == COGC_GATE_OFF)) begin
        gate_q <= HWDATA_I[1:0];
      end
      if (addr_q == COGC_ADDR_CORE) begin
        gear_q <= HWDATA_I[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator synchronisers and edge detection
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
      fast_s3_q <= 1'b0;
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      fast_s1_q <= FAST_OSC_I;
      fast_s2_q <= fast_s1_q;
      fast_s3_q <= fast_s2_q;
      slow_s1_q <= SLOW_OSC_I;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  assign fast_rise = fast_s2_q & ~fast_s3_q;
  assign slow_rise = slow_s2_q & ~slow_s3_q;

  ////////////////////////////////////////////////////////////////////////////////
  // clock outputs
  cogc_clkout u_out_first (
    .clk_i(CLOCK_I),
    .rst_n_i(ARST_N_I),
    .fast_lvl_i(fast_s2_q),
    .fast_rise_i(fast_rise),
    .slow_lvl_i(slow_s2_q),
    .slow_rise_i(slow_rise),
    .src_i(out_a_q[COGC_SRC_MSB:COGC_SRC_LSB]),
    .div_i(out_a_q[COGC_DIV_MSB:COGC_DIV_LSB]),
    .en_i(out_a_q[COGC_EN_BIT]),
    .clk_o(CLOCK_OUTPUT_FIRST_O)
  );

  cogc_clkout u_out_second (
    .clk_i(CLOCK_I),
    .rst_n_i(ARST_N_I),
    .fast_lvl_i(fast_s2_q),
    .fast_rise_i(fast_rise),
    .slow_lvl_i(slow_s2_q),
    .slow_rise_i(slow_rise),
    .src_i(out_b_q[COGC_SRC_MSB:COGC_SRC_LSB]),
    .div_i(out_b_q[COGC_DIV_MSB:COGC_DIV_LSB]),
    .en_i(out_b_q[COGC_EN_BIT]),
    .clk_o(CLOCK_OUTPUT_SECOND_O)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // settle wait targets; reserved slow codes take the long wait
  assign fast_target = COGC_FWT_BASE >> fast_wt_q;
  assign slow_target = (slow_wt_q == COGC_SWT_SHORT) ?
    COGC_WAIT_W'(SLOW_WAIT_SHORT) : COGC_WAIT_W'(SLOW_WAIT_LONG);

  // fast oscillator settle counter
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fast_cnt_q <= '0;
      fast_rdy_q <= 1'b0;
    end else if (!FAST_OSC_EN_I) begin
      fast_cnt_q <= '0;
      fast_rdy_q <= 1'b0;
    end else begin
      if (fast_rise && fast_cnt_q < fast_target) begin
        fast_cnt_q <= fast_cnt_q + COGC_WAIT_W'(1);
      end
      fast_rdy_q <= (fast_cnt_q >= fast_target);
    end
  end

  // slow oscillator settle counter
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      slow_cnt_q <= '0;
      slow_rdy_q <= 1'b0;
    end else if (!SLOW_OSC_EN_I) begin
      slow_cnt_q <= '0;
      slow_rdy_q <= 1'b0;
    end else begin
      if (slow_rise && slow_cnt_q < slow_target) begin
        slow_cnt_q <= slow_cnt_q + COGC_WAIT_W'(1);
      end
      slow_rdy_q <= (slow_cnt_q >= slow_target);
    end
  end

  assign FAST_OSC_READY_O = fast_rdy_q;
  assign SLOW_OSC_READY_O = slow_rdy_q;

  ////////////////////////////////////////////////////////////////////////////////
  // core clock enable pulse and peripheral gate
  assign gear_mask = 3'((4'h1 << gear_q) - 4'h1);

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gear_cnt_q <= 3'h0;
      core_en_q <= 1'b0;
      pclk_en_q <= 1'b0;
    end else begin
      gear_cnt_q <= gear_cnt_q + 3'h1;
      core_en_q <= ((gear_cnt_q & gear_mask) == gear_mask);
      pclk_en_q <= (gate_q == COGC_GATE_ON);
    end
  end

  assign CORE_CLK_EN_O = core_en_q;
  assign PERIPH_CLK_EN_O = pclk_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  bus_wait_state_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (state_q == COGC_ST_IDLE && accept) |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("bus answer not after one wait state");
  gear_read_back_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (state_q == COGC_ST_IDLE && accept && !HWRITE_I && HADDR_I == COGC_ADDR_CORE)
    |=> ##1 (HRDATA_O == {30'h0, gear_q}))
    else $error("core gear read back wrong");
  gate_follow_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    ARST_N_I |=> (PERIPH_CLK_EN_O == ($past(gate_q) == COGC_GATE_ON)))
    else $error("peripheral gate does not follow register");
  gate_forbid_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (wr_en && addr_q == COGC_ADDR_GATE && (HWDATA_I[1:0] == 2'h1 || HWDATA_I[1:0] == 2'h2))
    |=> $stable(gate_q))
    else $error("forbidden gate code was stored");
  gear_full_rate_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (ARST_N_I && gear_q == 2'h0) |=> CORE_CLK_EN_O)
    else $error("gear one does not pulse every cycle");
  gear_eighth_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (CORE_CLK_EN_O && $past(gear_q) == 2'h3) |-> ($past(gear_cnt_q) == 3'h7))
    else $error("gear eighth pulse at wrong phase");
  out_disable_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (!out_a_q[COGC_EN_BIT] && !out_b_q[COGC_EN_BIT])
    |=> (!CLOCK_OUTPUT_FIRST_O && !CLOCK_OUTPUT_SECOND_O))
    else $error("disabled output is driving");
  fast_wait_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (FAST_OSC_EN_I && fast_wt_q == 2'h3 && fast_cnt_q < 15'h0008) |=> !FAST_OSC_READY_O)
    else $error("fast oscillator ready before wait");
  slow_target_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (SLOW_OSC_EN_I && slow_wt_q == COGC_SWT_LONG && slow_cnt_q < 15'(SLOW_WAIT_LONG))
    |=> !SLOW_OSC_READY_O)
    else $error("slow ready before long wait");
  slow_drop_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    !SLOW_OSC_EN_I |=> (!SLOW_OSC_READY_O && slow_cnt_q == '0))
    else $error("slow ready survives disable");

endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import cogc_pkg::*;

  localparam int SWL = 20;
  localparam int SWS = 6;
  localparam int WD_CYC = 90000;

  typedef struct {
    string name;
    logic [31:0] val;
  } cogc_note_t;

  ////////////////////////////////////////////////////////////////////////////////
  // design connections
  logic CLOCK_I, ARST_N_I, HSEL_I, HWRITE_I, HREADY_I;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O;
  logic [1:0] HTRANS_I;
  logic [2:0] HSIZE_I;
  logic HREADYOUT_O, HRESP_O;
  logic FAST_OSC_I, SLOW_OSC_I, FAST_OSC_EN_I, SLOW_OSC_EN_I;
  logic CLOCK_OUTPUT_FIRST_O, CLOCK_OUTPUT_SECOND_O, FAST_OSC_READY_O, SLOW_OSC_READY_O;
  logic PERIPH_CLK_EN_O, CORE_CLK_EN_O;
  cogc_note_t exp_q[$];
  logic [31:0] seen_q[$];
  int n_mismatch = 0;
  int checks = 0;
  logic rd_ph = 1'b0;

  cogc_top #(.SLOW_WAIT_LONG(SWL), .SLOW_WAIT_SHORT(SWS)) dut_u (
    .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .FAST_OSC_I(FAST_OSC_I), .SLOW_OSC_I(SLOW_OSC_I), .FAST_OSC_EN_I(FAST_OSC_EN_I),
    .SLOW_OSC_EN_I(SLOW_OSC_EN_I), .CLOCK_OUTPUT_FIRST_O(CLOCK_OUTPUT_FIRST_O),
    .CLOCK_OUTPUT_SECOND_O(CLOCK_OUTPUT_SECOND_O), .FAST_OSC_READY_O(FAST_OSC_READY_O),
    .SLOW_OSC_READY_O(SLOW_OSC_READY_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
    .CORE_CLK_EN_O(CORE_CLK_EN_O)
  );

  // single slave, so its ready is the bus ready
  assign HREADY_I = HREADYOUT_O;

  ////////////////////////////////////////////////////////////////////////////////
  // clocks and oscillators, oscillators free of the system clock phase
  initial begin
    CLOCK_I = 1'b0;
    forever #4 CLOCK_I = ~CLOCK_I;
  end
  initial begin
    FAST_OSC_I = 1'b0;
    #3;
    forever #16 FAST_OSC_I = ~FAST_OSC_I;
  end
  initial begin
    SLOW_OSC_I = 1'b0;
    #7;
    forever #40 SLOW_OSC_I = ~SLOW_OSC_I;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic note(input string name, input logic [31:0] val);
    exp_q.push_back('{name, val});
  endtask

  // counts within tolerance are reported as the exact figure
  function automatic int norm(input int c, input int e, input int tol);
    return ((c >= e - tol) && (c <= e + tol)) ? e : c;
  endfunction

  task automatic print_verdict;
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read data monitor and comparer
  always @(posedge CLOCK_I) begin
    if (rd_ph && HREADYOUT_O === 1'b1) seen_q.push_back(HRDATA_O);
    if (HREADYOUT_O === 1'b1) rd_ph = HSEL_I && HTRANS_I[1] && !HWRITE_I;
  end
  initial forever begin
    @(negedge CLOCK_I);
    while (seen_q.size() > 0) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("Error unexpected result expected none seen %h", seen_q.pop_front());
      end else begin
        check(exp_q[0].name, exp_q[0].val, seen_q.pop_front());
        void'(exp_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite master, single word transfers
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge CLOCK_I);
    HSEL_I <= 1'b1;
    HADDR_I <= addr;
    HTRANS_I <= 2'h2;
    HWRITE_I <= wr;
    @(posedge CLOCK_I);
    while (HREADYOUT_O !== 1'b1) @(posedge CLOCK_I);
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    @(posedge CLOCK_I);
    while (HREADYOUT_O !== 1'b1) @(posedge CLOCK_I);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [7:0] d);
    bus(1'b1, addr, {24'h000000, d});
  endtask

  task automatic rd(input logic [31:0] addr, input logic [7:0] e, input string name);
    note(name, {24'h000000, e});
    bus(1'b0, addr, 32'h00000000);
    // let the monitor queue the read data before anything else is queued
    @(negedge CLOCK_I);
    note("bus response", 32'h00000000);
    seen_q.push_back({31'h00000000, HRESP_O});
  endtask

  // counts rising edges of one clock output over t cycles
  task automatic meas(input logic sec, input logic [7:0] val, input int t, input int e);
    int c;
    logic prev, cur;
    c = 0;
    wr(sec ? COGC_ADDR_OUT_B : COGC_ADDR_OUT_A, val);
    repeat (16) @(posedge CLOCK_I);
    prev = sec ? CLOCK_OUTPUT_SECOND_O : CLOCK_OUTPUT_FIRST_O;
    repeat (t) begin
      @(posedge CLOCK_I);
      cur = sec ? CLOCK_OUTPUT_SECOND_O : CLOCK_OUTPUT_FIRST_O;
      if (cur === 1'b1 && prev === 1'b0) c++;
      prev = cur;
    end
    note("clock output edges", e);
    seen_q.push_back(norm(c, e, (e == 0) ? 0 : 1));
  endtask

  // counts oscillator edges from enable until ready
  task automatic settle(input logic fast, input logic [7:0] val, input int e);
    int c;
    logic prev, cur;
    c = 0;
    wr(COGC_ADDR_WAIT, val);
    if (fast) FAST_OSC_EN_I <= 1'b0;
    else SLOW_OSC_EN_I <= 1'b0;
    repeat (4) @(posedge CLOCK_I);
    note("ready while disabled", 0);
    seen_q.push_back(fast ? FAST_OSC_READY_O : SLOW_OSC_READY_O);
    if (fast) FAST_OSC_EN_I <= 1'b1;
    else SLOW_OSC_EN_I <= 1'b1;
    prev = fast ? FAST_OSC_I : SLOW_OSC_I;
    for (int i = 0; i < 20000 && (fast ? FAST_OSC_READY_O : SLOW_OSC_READY_O) !== 1'b1; i++) begin
      @(posedge CLOCK_I);
      cur = fast ? FAST_OSC_I : SLOW_OSC_I;
      if (cur && !prev) c++;
      prev = cur;
    end
    note("settle edges", e);
    seen_q.push_back(norm(c, e, 2));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #(WD_CYC * 8);
    n_mismatch++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] addrs[4];
    logic [7:0] masks[4];
    logic [7:0] gw[5];
    logic [7:0] ge[5];
    logic [7:0] d;
    int c;
    addrs = '{COGC_ADDR_OUT_A, COGC_ADDR_OUT_B, COGC_ADDR_WAIT, COGC_ADDR_CORE};
    masks = '{8'h7D, 8'h7D, 8'hC3, 8'h03};
    gw = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h01};
    ge = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h03};
    ARST_N_I = 1'b0;
    HSEL_I = 1'b0;
    HADDR_I = 32'h00000000;
    HTRANS_I = 2'h0;
    HWRITE_I = 1'b0;
    HSIZE_I = 3'h2;
    HWDATA_I = 32'h00000000;
    FAST_OSC_EN_I = 1'b1;
    SLOW_OSC_EN_I = 1'b1;
    void'($urandom(11));
    repeat (16) @(posedge CLOCK_I);
    ARST_N_I <= 1'b1;
    // reset values
    rd(COGC_ADDR_OUT_A, 8'h00, "out a reset");
    rd(COGC_ADDR_OUT_B, 8'h00, "out b reset");
    rd(COGC_ADDR_WAIT, 8'h00, "wait reset");
    rd(COGC_ADDR_GATE, 8'h03, "gate reset");
    rd(COGC_ADDR_CORE, 8'h00, "core reset");
    note("periph enable at reset", 1);
    seen_q.push_back(PERIPH_CLK_EN_O);
    // random write and read back, reserved bits read zero
    repeat (4) begin
      for (int i = 0; i < 4; i++) begin
        d = 8'($urandom);
        wr(addrs[i], d);
        rd(addrs[i], d & masks[i], "register readback");
      end
    end
    // unmapped address
    wr(COGC_ADDR_CORE + 32'h4, 8'hFF);
    rd(COGC_ADDR_CORE + 32'h4, 8'h00, "unmapped read");
    // peripheral gate, forbidden codes keep the old value
    for (int i = 0; i < 5; i++) begin
      wr(COGC_ADDR_GATE, gw[i]);
      rd(COGC_ADDR_GATE, ge[i], "gate value");
      repeat (2) @(posedge CLOCK_I);
      note("periph enable", ge[i] == 8'h03);
      seen_q.push_back(PERIPH_CLK_EN_O);
    end
    // core clock gear ratios
    for (int g = 0; g < 4; g++) begin
      wr(COGC_ADDR_CORE, 8'(g));
      repeat (8) @(posedge CLOCK_I);
      c = 0;
      repeat (64) begin
        @(posedge CLOCK_I);
        if (CORE_CLK_EN_O === 1'b1) c++;
      end
      note("core pulses", 64 >> g);
      seen_q.push_back(c);
    end
    // first output, fast source, every divider code
    for (int n = 0; n < 8; n++) begin
      meas(1'b0, 8'((n << 4) | 1), 2048, 512 >> n);
    end
    meas(1'b0, 8'h30, 2048, 0);
    meas(1'b0, 8'h09, 2048, 0);
    meas(1'b0, 8'h0D, 2048, 0);
    // second output, slow source, then fast source divided by 8
    meas(1'b1, 8'h05, 2560, 256);
    meas(1'b1, 8'h35, 2560, 32);
    meas(1'b1, 8'h75, 2560, 2);
    meas(1'b1, 8'h04, 2560, 0);
    meas(1'b1, 8'h31, 2560, 80);
    // oscillator settle waits
    for (int k = 0; k < 4; k++) begin
      settle(1'b1, 8'(k << 6), 64 >> k);
    end
    settle(1'b0, 8'h00, SWL);
    settle(1'b0, 8'h02, SWS);
    settle(1'b0, 8'h01, SWL);
    repeat (4) @(posedge CLOCK_I);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("Error pending results expected 0 seen %0d", exp_q.size());
    end
    print_verdict();
  end
endmodule
